// ==== src/oswd_regs.svh ====
// Constants of the on-screen-display serial write decoder.
`ifndef OSWD_REGS_SVH
`define OSWD_REGS_SVH
`define OSWD_I2C_ADDR      8'h7A
`define OSWD_BYTE_BITS     4'h8
`define OSWD_B_ROW_FLAG    7
`define OSWD_B_FONT_SEL    6
`define OSWD_B_PLANE_SEL   5
`define OSWD_B_FMT_C       6
`define OSWD_B_CODE_MSB    5
`define OSWD_SYNC_SCK      0
`define OSWD_SYNC_SDA      1
`define OSWD_SYNC_SEL      2
`endif

// ==== src/oswd_pkg.sv ====
// Types of the on-screen-display serial write decoder.
package oswd_pkg;

  typedef enum logic [1:0] {
    OSWD_TGT_CHAR = 2'b00,
    OSWD_TGT_ATTR = 2'b01,
    OSWD_TGT_FONT = 2'b10
  } oswd_tgt_e;

  typedef enum logic [1:0] {
    OSWD_DEC_ROW   = 2'b00,
    OSWD_DEC_COL   = 2'b01,
    OSWD_DEC_DATA  = 2'b10,
    OSWD_DEC_BURST = 2'b11
  } oswd_dec_e;

  typedef struct packed {
    oswd_tgt_e   target;
    logic [4:0]  row;
    logic [5:0]  col;
    logic [8:0]  data;
  } oswd_wr_s;

  typedef struct packed {
    logic [2:0]  meta;
    logic [2:0]  stable;
  } oswd_sync_s;

  typedef struct packed {
    logic        sck_prev;
    logic        sda_prev;
    logic        sel_prev;
    logic [7:0]  shift;
    logic [3:0]  bit_cnt;
    logic        i2c_active;
    logic        i2c_addr_phase;
    logic        i2c_ack;
    oswd_dec_e   dec;
    logic        fmt_c;
    logic        font_msb;
    oswd_wr_s    addr;
    logic        wr_valid;
    oswd_wr_s    wr;
    logic        is_i2c;
  } oswd_state_s;

endpackage

// ==== src/oswd_sync.sv ====
// Two-stage synchroniser for the serial pins.
`timescale 1ns/1ps
module oswd_sync (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [2:0] pins_i,
  output logic      [2:0] pins_o
);
  oswd_pkg::oswd_sync_s s_q;
  oswd_pkg::oswd_sync_s s_d;

  always_comb begin
    s_d.meta   = pins_i;
    s_d.stable = s_q.meta;
  end

  // Reset value is idle-high, matching the pull-ups on the serial pins.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_q <= '{meta: 3'h7, stable: 3'h7};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o = s_q.stable;
endmodule // oswd_sync

// ==== src/oswd_write_decoder.sv ====
// Serial byte receiver and packet decoder that issues display writes.
`timescale 1ns/1ps
`include "oswd_regs.svh"
//
// Contract
// R1 - SPI when select pin is driven high or low; I2C only when floating.
// R2 - SPI master holds select low from transfer start through last clock.
// R3 - I2C transfers start with write address 7AH; others are ignored.
// R4 - Accept formats a (R-C-D repeated), b (R-C-D then C-D), c (R-C-D-D...).
// R5 - Byte bit 7 set marks a row byte, clear a column byte.
// R6 - Row bit 6 picks display registers (row 4:0) or user font (row 2:0).
// R7 - Display row bit 5 picks character-code plane or attribute plane.
// R8 - Column bit 6 marks format c; column is bits 4:0 or font bits 5:0.
// R9 - Character column bit 5 gives code bit 8; data gives bits 7:0.
// R10 - In format c the latched code bit 8 holds for all later data.
// R11 - In format c the write address advances after every data byte.
// R12 - Format a may go to b or c, b to a; c never leaves.
// R13 - Writes wait for the display timing slot before reaching the bus.
// R14 - Master should fill undefined locations with dummy data.
// R15 - Display array covers rows 0-14, columns 0-29, row control at 30.
// R16 - SPI data sampled on rising serial clock, most significant bit first.
// R17 - Select release or I2C stop returns to row wait, dropping partial byte.
// R18 - I2C address and every data byte are acknowledged.
module oswd_write_decoder #(
  parameter logic [7:0] I2C_ADDR = `OSWD_I2C_ADDR
) (
  input  wire logic                sys_clk_i,
  input  wire logic                srst_i,
  input  wire logic                sck_i,
  input  wire logic                sda_i,
  input  wire logic                serial_select_pin_i,
  input  wire logic                serial_select_float_i,
  input  wire logic                wr_slot_i,
  output logic                     sda_o,
  output logic                     sda_oe_o,
  output logic                     bus_is_i2c_o,
  output logic                     wr_valid_o,
  output oswd_pkg::oswd_tgt_e      wr_target_o,
  output logic               [4:0] wr_row_o,
  output logic               [5:0] wr_col_o,
  output logic               [8:0] wr_data_o
);

  if (I2C_ADDR[0] != 1'b0) begin : g_addr_check
    $error("I2C_ADDR must be a write address with bit 0 clear.");
  end

  logic [2:0] pins_s;
  logic       float_s;

  oswd_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .pins_i    ({serial_select_pin_i, sda_i, sck_i}),
    .pins_o    (pins_s)
  );

  // The float indication is a pad-detector level from outside the clock.
  logic float_m_q;
  logic float_q;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      float_m_q <= 1'b0;
      float_q   <= 1'b0;
    end else begin
      float_m_q <= serial_select_float_i;
      float_q   <= float_m_q;
    end
  end
  assign float_s = float_q;

  oswd_pkg::oswd_state_s s_q;
  oswd_pkg::oswd_state_s s_d;

  logic       sck_s;
  logic       sda_s;
  logic       sel_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       i2c_start;
  logic       i2c_stop;
  logic       byte_v;
  logic [7:0] byte_b;
  logic       dec_reset;
  logic       do_write;
  logic [7:0] shifted;

  always_comb begin
    sck_s     = pins_s[`OSWD_SYNC_SCK];
    sda_s     = pins_s[`OSWD_SYNC_SDA];
    sel_s     = pins_s[`OSWD_SYNC_SEL];
    sck_rise  = sck_s & ~s_q.sck_prev;
    sck_fall  = ~sck_s & s_q.sck_prev;
    i2c_start = s_q.is_i2c & sck_s & s_q.sck_prev & ~sda_s & s_q.sda_prev;
    i2c_stop  = s_q.is_i2c & sck_s & s_q.sck_prev & sda_s & ~s_q.sda_prev;
    shifted   = {s_q.shift[6:0], sda_s}; // [R16]
    byte_v    = 1'b0;
    byte_b    = s_q.shift;
    dec_reset = 1'b0;
    do_write  = 1'b0;

    s_d          = s_q;
    s_d.sck_prev = sck_s;
    s_d.sda_prev = sda_s;
    s_d.sel_prev = sel_s;
    s_d.is_i2c   = float_s; // [R1]

    if (s_q.is_i2c != float_s) begin
      s_d.bit_cnt    = 4'h0;
      s_d.i2c_active = 1'b0;
      s_d.i2c_ack    = 1'b0;
      dec_reset      = 1'b1;
    end else if (!s_q.is_i2c) begin
      // SPI: a high select discards any partial byte and restarts packets.
      if (sel_s) begin // [R2]
        s_d.bit_cnt = 4'h0;
        dec_reset   = 1'b1; // [R17]
      end else if (sck_rise) begin // [R16]
        s_d.shift = shifted;
        if (s_q.bit_cnt == `OSWD_BYTE_BITS - 4'h1) begin
          s_d.bit_cnt = 4'h0;
          byte_v      = 1'b1;
          byte_b      = shifted;
        end else begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
      end
    end else if (i2c_stop) begin
      s_d.i2c_active = 1'b0;
      s_d.i2c_ack    = 1'b0;
      s_d.bit_cnt    = 4'h0;
      dec_reset      = 1'b1; // [R17]
    end else if (i2c_start) begin
      s_d.i2c_active     = 1'b1;
      s_d.i2c_addr_phase = 1'b1;
      s_d.i2c_ack        = 1'b0;
      s_d.bit_cnt        = 4'h0;
      dec_reset          = 1'b1;
    end else if (s_q.i2c_active) begin
      if (sck_rise && !s_q.i2c_ack && s_q.bit_cnt != `OSWD_BYTE_BITS) begin
        s_d.shift   = shifted;
        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
      end else if (sck_fall && s_q.i2c_ack) begin
        s_d.i2c_ack = 1'b0; // [R18]
      end else if (sck_fall && s_q.bit_cnt == `OSWD_BYTE_BITS) begin
        s_d.bit_cnt = 4'h0;
        if (s_q.i2c_addr_phase) begin
          // A foreign or read address leaves the bus to other slaves.
          if (s_q.shift == I2C_ADDR) begin // [R3]
            s_d.i2c_addr_phase = 1'b0;
            s_d.i2c_ack        = 1'b1; // [R18]
          end else begin
            s_d.i2c_active = 1'b0;
          end
        end else begin
          s_d.i2c_ack = 1'b1; // [R18]
          byte_v      = 1'b1;
        end
      end
    end

    if (dec_reset) begin
      s_d.dec = oswd_pkg::OSWD_DEC_ROW; // [R17]
    end else if (byte_v) begin
      unique case (s_q.dec)
        oswd_pkg::OSWD_DEC_ROW, oswd_pkg::OSWD_DEC_COL: begin
          if (byte_b[`OSWD_B_ROW_FLAG]) begin // [R5]
            s_d.addr.row = 5'h00;
            if (byte_b[`OSWD_B_FONT_SEL]) begin // [R6]
              s_d.addr.target  = oswd_pkg::OSWD_TGT_FONT;
              s_d.addr.row[2:0] = byte_b[2:0];
            end else begin
              s_d.addr.row    = byte_b[4:0];
              s_d.addr.target = byte_b[`OSWD_B_PLANE_SEL] ? // [R7]
                oswd_pkg::OSWD_TGT_ATTR : oswd_pkg::OSWD_TGT_CHAR;
            end
            s_d.dec = oswd_pkg::OSWD_DEC_COL;
          end else if (s_q.dec == oswd_pkg::OSWD_DEC_COL) begin
            s_d.fmt_c = byte_b[`OSWD_B_FMT_C]; // [R8]
            if (s_q.addr.target == oswd_pkg::OSWD_TGT_FONT) begin
              s_d.addr.col = byte_b[5:0]; // [R8]
            end else begin
              s_d.addr.col = {1'b0, byte_b[4:0]}; // [R8]
            end
            if (s_q.addr.target == oswd_pkg::OSWD_TGT_CHAR) begin
              s_d.font_msb = byte_b[`OSWD_B_CODE_MSB]; // [R9] [R10]
            end
            s_d.dec = oswd_pkg::OSWD_DEC_DATA;
          end
        end
        oswd_pkg::OSWD_DEC_DATA: begin
          do_write = 1'b1;
          // Format c is a one-way door; a/b fall back to row-or-column.
          s_d.dec = s_q.fmt_c ? oswd_pkg::OSWD_DEC_BURST // [R12] [R4]
                              : oswd_pkg::OSWD_DEC_COL;
        end
        oswd_pkg::OSWD_DEC_BURST: begin
          do_write = 1'b1; // [R12]
        end
      endcase
    end

    // A write handed over in the slot is retired; a new one wins the cycle.
    if (wr_slot_i) begin
      s_d.wr_valid = 1'b0; // [R13]
    end
    if (do_write) begin
      s_d.wr_valid    = 1'b1; // [R13]
      s_d.wr          = s_q.addr;
      s_d.wr.data     = {1'b0, byte_b};
      if (s_q.addr.target == oswd_pkg::OSWD_TGT_CHAR) begin
        s_d.wr.data = {s_q.font_msb, byte_b}; // [R9] [R10]
      end
      if (s_q.fmt_c) begin
        // Linear advance over the full column space; the master pads the
        // unused columns with dummy bytes.
        if (s_q.addr.target == oswd_pkg::OSWD_TGT_FONT) begin // [R11]
          {s_d.addr.row[2:0], s_d.addr.col} =
            9'({s_q.addr.row[2:0], s_q.addr.col} + 9'h001);
        end else begin
          {s_d.addr.row, s_d.addr.col[4:0]} = // [R11] [R14] [R15]
            10'({s_q.addr.row, s_q.addr.col[4:0]} + 10'h001);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_q <= '{sck_prev: 1'b1, sda_prev: 1'b1, sel_prev: 1'b1,
               dec: oswd_pkg::OSWD_DEC_ROW,
               addr: '{target: oswd_pkg::OSWD_TGT_CHAR, default: '0},
               wr: '{target: oswd_pkg::OSWD_TGT_CHAR, default: '0},
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_o        = 1'b0 & s_q.i2c_ack;
  assign sda_oe_o     = s_q.i2c_ack; // [R18]
  assign bus_is_i2c_o = s_q.is_i2c;
  assign wr_valid_o   = s_q.wr_valid;
  assign wr_target_o  = s_q.wr.target;
  assign wr_row_o     = s_q.wr.row;
  assign wr_col_o     = s_q.wr.col;
  assign wr_data_o    = s_q.wr.data;
endmodule // oswd_write_decoder

// ==== verification/oswd_checker.sv ====
// Port assertions for the serial write decoder.
`timescale 1ns/1ps
module oswd_checker (
  input wire logic                sys_clk_i,
  input wire logic                srst_i,
  input wire logic                wr_slot_i,
  input wire logic                sda_o,
  input wire logic                sda_oe_o,
  input wire logic                bus_is_i2c_o,
  input wire logic                wr_valid_o,
  input wire oswd_pkg::oswd_tgt_e wr_target_o,
  input wire logic          [4:0] wr_row_o,
  input wire logic          [5:0] wr_col_o,
  input wire logic          [8:0] wr_data_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_spi_no_ack: assert property (!bus_is_i2c_o |-> !sda_oe_o)
    else $error("ack driven in spi mode");
  a_ack_low: assert property (sda_oe_o |-> !sda_o)
    else $error("ack not low");
  a_ack_short: assert property (sda_oe_o |-> ##[1:30] !sda_oe_o)
    else $error("ack held too long");
  a_valid_hold: assert property (wr_valid_o && !wr_slot_i |=>
    wr_valid_o && $stable(wr_target_o)) else $error("write lost");
  // A new write in the slot cycle keeps valid high but moves the fields.
  a_slot_take: assert property (wr_valid_o && wr_slot_i |=>
    !wr_valid_o || !$stable({wr_row_o, wr_col_o, wr_data_o}))
    else $error("write not taken");
  a_font_row: assert property (wr_valid_o &&
    wr_target_o == oswd_pkg::OSWD_TGT_FONT |-> wr_row_o[4:3] == 2'b00)
    else $error("font row too wide");
  a_no_msb: assert property (wr_valid_o &&
    wr_target_o != oswd_pkg::OSWD_TGT_CHAR |-> !wr_data_o[8])
    else $error("code msb outside char plane");
  a_disp_col: assert property (wr_valid_o &&
    wr_target_o != oswd_pkg::OSWD_TGT_FONT |-> !wr_col_o[5])
    else $error("display column too wide");
endmodule // oswd_checker
bind oswd_write_decoder oswd_checker u_chk (.sys_clk_i, .srst_i, .wr_slot_i,
  .sda_o, .sda_oe_o, .bus_is_i2c_o, .wr_valid_o, .wr_target_o, .wr_row_o,
  .wr_col_o, .wr_data_o);

// ==== verification/oswd_mcu_model.sv ====
// Behavioural serial master driving the decoder pins.
`timescale 1ns/1ps
module oswd_mcu_model (
  input  wire logic sda_i,
  output logic      sck_o,
  output logic      sda_o,
  output logic      sel_o,
  output logic      flt_o
);
  // Pulled-up lines rest high whenever this master lets go.
  initial begin
    sck_o = 1'b1;
    sda_o = 1'b1;
    sel_o = 1'b1;
    flt_o = 1'b0;
  end
  task automatic frame(input logic v);
    sel_o = v;
    sda_o = 1'b1;
    #48;
  endtask
  // Data moves while the clock is low, a little after the fall.
  task automatic bit_io(input logic b, output logic r);
    sck_o = 1'b0;
    #4 sda_o = b;
    #20 sck_o = 1'b1;
    #12 r = sda_i;
    #12;
  endtask
  task automatic start();
    sda_o = 1'b0;
    #24;
  endtask
  task automatic stop();
    sck_o = 1'b0;
    #4 sda_o = 1'b0;
    #20 sck_o = 1'b1;
    #24 sda_o = 1'b1;
    #24;
  endtask
endmodule // oswd_mcu_model

// ==== verification/osd_serial_write_decoder_tb.sv ====
// Self-checking bench for the serial write decoder.
`timescale 1ns/1ps
module osd_serial_write_decoder_tb;
  logic clk, srst, slot, sck, sda_m, sel, flt, sda_d, oe, i2c, vld, r;
  oswd_pkg::oswd_tgt_e tgt, tg;
  logic [4:0] row, rw;
  logic [5:0] col, cl;
  logic [8:0] dat;
  logic d8;
  int st, cyc, miscompares, n_tests;
  oswd_pkg::oswd_wr_s exp_q[$];
  wire sda_ln = sda_m & (!oe | sda_d);
  oswd_mcu_model m (.sda_i(sda_ln), .sck_o(sck), .sda_o(sda_m),
    .sel_o(sel), .flt_o(flt));
  oswd_write_decoder DUT (.sys_clk_i(clk), .srst_i(srst), .sck_i(sck),
    .sda_i(sda_ln), .serial_select_pin_i(sel),
    .serial_select_float_i(flt), .wr_slot_i(slot), .sda_o(sda_d),
    .sda_oe_o(oe), .bus_is_i2c_o(i2c), .wr_valid_o(vld),
    .wr_target_o(tgt), .wr_row_o(row), .wr_col_o(col), .wr_data_o(dat));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] b, input logic ak);
    for (int i = 7; i >= 0; i--) m.bit_io(b[i], r);
    if (flt) begin
      m.bit_io(1'b1, r);
      cmp(!r, ak);
    end
  endtask
  // The expectation is queued first, then the model moves, so the write is queued before it can appear.
  task automatic send(input logic [7:0] b);
    if (st >= 2) begin
      exp_q.push_back('{tg, rw, cl, {tg == oswd_pkg::OSWD_TGT_CHAR && d8, b}});
      if (st == 2) st = 1;
      else if (tg == oswd_pkg::OSWD_TGT_FONT)
        {rw[2:0], cl} = {rw[2:0], cl} + 9'h001;
      else
        {rw, cl[4:0]} = {rw, cl[4:0]} + 10'h001;
    end else if (b[7]) begin
      tg = b[6] ? oswd_pkg::OSWD_TGT_FONT : b[5] ? oswd_pkg::OSWD_TGT_ATTR
                                                 : oswd_pkg::OSWD_TGT_CHAR;
      rw = b[6] ? {2'b00, b[2:0]} : b[4:0];
      st = 1;
    end else if (st == 1) begin
      cl = tg == oswd_pkg::OSWD_TGT_FONT ? b[5:0] : {1'b0, b[4:0]};
      if (tg == oswd_pkg::OSWD_TGT_CHAR) d8 = b[5];
      st = b[6] ? 3 : 2;
    end
    xfer(b, 1'b1);
  endtask
  task automatic rnd_pkt();
    send(8'h80 | 8'($urandom % 15));
    send(8'($urandom % 64));
    send(8'($urandom));
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1 slot = 1'($urandom);
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end
  always @(posedge clk) if (!srst && vld && slot)
    cmp({tgt, row, col, dat}, exp_q.size() ? exp_q.pop_front() : '1);
  initial begin
    srst = 1'b1;
    slot = 1'b0;
    st = 0;
    d8 = 1'b0;
    r = $urandom(32'hb919);
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge clk);
    cmp(i2c, 1'b0);
    m.frame(1'b0);
    rnd_pkt();
    send(8'hA0 | 8'($urandom % 15));
    send(8'h20 | 8'($urandom % 30));
    send(8'($urandom));
    send(8'($urandom % 30));
    send(8'($urandom));
    send(8'hC0 | 8'($urandom % 64));
    send(8'h7F);
    repeat (3) send(8'($urandom));
    m.frame(1'b1);
    st = 0;
    m.frame(1'b0);
    repeat (3) m.bit_io(1'b1, r);
    m.frame(1'b1);
    m.frame(1'b0);
    send(8'h05);
    send(8'h8E);
    send(8'h7F);
    repeat (3) send(8'($urandom));
    send(8'hC5);
    m.frame(1'b1);
    st = 0;
    m.flt_o = 1'b1;
    repeat (10) @(posedge clk);
    cmp(i2c, 1'b1);
    // A floating select pin carries no meaning, so any level must be ignored.
    m.sel_o = 1'($urandom);
    m.start();
    xfer(8'h7A, 1'b1);
    rnd_pkt();
    rnd_pkt();
    m.stop();
    st = 0;
    m.start();
    xfer(8'h7C, 1'b0);
    repeat (3) xfer(8'($urandom), 1'b0);
    m.stop();
    m.start();
    xfer(8'h7A, 1'b1);
    rnd_pkt();
    m.stop();
    repeat (50) @(posedge clk);
    cmp(exp_q.size(), 0);
    report_and_stop();
  end
endmodule // osd_serial_write_decoder_tb
